// >>> l4ae_pkg.sv
// constants shared by the layer-4 access control entry matcher
// assumes a single core clock and a plain strobe register port
// Notes on behaviour
// R1 - source port range match, bounds 0 to 65535
// R2 - destination port any ignores destination port
// R3 - destination single mode needs exact port equality
// R4 - destination range mode matches within both bounds
// R5 - flag set: only TCP frames with flag
// R6 - flag unset: TCP frames with flag refused
// R7 - flag don't care accepts either value
// R8 - type of service any ignores the byte
// R9 - DSCP mode needs equal six-bit code
// R10 - precedence mode needs equal three-bit value
// R11 - ICMP any leaves type and identifier free
// R12 - ICMP list matches type picked from table
// R13 - protocol identifier mode needs equal identifier
// R14 - ICMP code any skips the code compare
// R15 - ICMP code user mode needs equal code
// R16 - permit action keeps hit frames forwardable
// R17 - deny action discards hit frames
// R18 - hit only when all criteria match together
// R19 - ranges inclusive; inverted range never matches
package l4ae_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SRC_PORT = 8'h04;
    localparam logic [7:0] ADDR_DST_PORT = 8'h08;
    localparam logic [7:0] ADDR_TCP_FLAGS = 8'h0c;
    localparam logic [7:0] ADDR_TOS = 8'h10;
    localparam logic [7:0] ADDR_ICMP = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;

    // control register fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_DENY_BIT = 1;
    localparam int CTRL_SRC_POS = 2;
    localparam int CTRL_DST_POS = 4;
    localparam int CTRL_TOS_POS = 6;
    localparam int CTRL_ICMP_POS = 8;
    localparam int CTRL_CODE_BIT = 10;
    localparam logic [31:0] CTRL_MASK = 32'h0000_07ff;

    // port registers: low bound in the low half, high bound above
    localparam int PORT_LO_POS = 0;
    localparam int PORT_HI_POS = 16;

    // flag register: two bits per flag, flag i at bit 2*i
    localparam int NUM_FLAGS = 6;
    localparam logic [31:0] FLAGS_MASK = 32'h0000_0fff;

    // type of service register fields
    localparam int TOS_DSCP_POS = 0;
    localparam int TOS_PREC_POS = 8;
    localparam logic [31:0] TOS_MASK = 32'h0000_073f;

    // icmp register fields
    localparam int ICMP_LIST_POS = 0;
    localparam int ICMP_PROTO_POS = 8;
    localparam int ICMP_CODE_POS = 16;
    localparam logic [31:0] ICMP_MASK = 32'h00ff_ff0f;

    // status register fields
    localparam int STAT_LAST_HIT_BIT = 16;
    localparam int STAT_LAST_DROP_BIT = 17;

    // values after reset
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] PORT_RESET = 32'hffff_0000;
    localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
    localparam logic [31:0] TOS_RESET = 32'h0000_0000;
    localparam logic [31:0] ICMP_RESET = 32'h0000_0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;

    // criterion modes
    localparam logic [1:0] PMODE_ANY = 2'h0;
    localparam logic [1:0] PMODE_SINGLE = 2'h1;
    localparam logic [1:0] PMODE_RANGE = 2'h2;
    localparam logic [1:0] FLAG_DONT_CARE = 2'h0;
    localparam logic [1:0] FLAG_SET = 2'h1;
    localparam logic [1:0] FLAG_UNSET = 2'h2;
    localparam logic [1:0] TOS_ANY = 2'h0;
    localparam logic [1:0] TOS_DSCP = 2'h1;
    localparam logic [1:0] TOS_PREC = 2'h2;
    localparam logic [1:0] ICMP_ANY = 2'h0;
    localparam logic [1:0] ICMP_LIST = 2'h1;
    localparam logic [1:0] ICMP_PROTO = 2'h2;

    // predefined icmp type list: {valid, type}
    function automatic logic [8:0] icmp_list_type(input logic [3:0] idx);
        case (idx)
            4'h0: return {1'b1, 8'h00};
            4'h1: return {1'b1, 8'h03};
            4'h2: return {1'b1, 8'h04};
            4'h3: return {1'b1, 8'h05};
            4'h4: return {1'b1, 8'h08};
            4'h5: return {1'b1, 8'h0b};
            4'h6: return {1'b1, 8'h0c};
            4'h7: return {1'b1, 8'h0d};
            4'h8: return {1'b1, 8'h0e};
            4'h9: return {1'b1, 8'h0f};
            4'ha: return {1'b1, 8'h10};
            default: return {1'b0, 8'h00};
        endcase
    endfunction

endpackage

// >>> l4ae_port_match.sv
// single value or inclusive range compare of one layer-4 port
// assumes the caller flags whether the frame carries a port at all
`timescale 1ns/1ns
module l4ae_port_match #(
    parameter int PORT_W = 16
) (
    input wire logic [1:0] mode,
    input wire logic [PORT_W-1:0] lo,
    input wire logic [PORT_W-1:0] hi,
    input wire logic [PORT_W-1:0] port,
    input wire logic has_port,
    output logic match
);

    always_comb begin
        case (mode)
            l4ae_pkg::PMODE_ANY: begin
                match = 1'b1; // see R2
            end
            l4ae_pkg::PMODE_SINGLE: begin
                match = has_port && (port == lo); // see R3
            end
            l4ae_pkg::PMODE_RANGE: begin
                // inverted bounds let no port pass both compares at once
                match = has_port && port >= lo && port <= hi; // see R1 R4 R19
            end
            default: begin
                match = 1'b0;
            end
        endcase
    end

endmodule

// >>> l4ae_entry_matcher.sv
// one layer-4 access control entry: criteria registers and hit decision
// assumes parsed header fields arrive on clk with a one-cycle valid
`timescale 1ns/1ns
module l4ae_entry_matcher #(
    parameter int PORT_W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic frm_valid,
    input wire logic frm_is_ip,
    input wire logic frm_is_tcp,
    input wire logic frm_is_udp,
    input wire logic frm_is_icmp,
    input wire logic [7:0] frm_ip_proto,
    input wire logic [PORT_W-1:0] frm_src_port,
    input wire logic [PORT_W-1:0] frm_dst_port,
    input wire logic [5:0] frm_tcp_flags,
    input wire logic [7:0] frm_tos,
    input wire logic [7:0] frm_icmp_type,
    input wire logic [7:0] frm_icmp_code,
    output logic res_valid,
    output logic res_hit,
    output logic res_permit,
    output logic res_drop
);

    logic [31:0] ctrl, src_cfg, dst_cfg, flag_cfg, tos_cfg, icmp_cfg;
    logic [31:0] next_ctrl, next_src_cfg, next_dst_cfg, next_flag_cfg;
    logic [31:0] next_tos_cfg, next_icmp_cfg, next_rdata;
    logic [15:0] hit_count, next_hit_count;
    logic last_hit, last_drop, next_last_hit, next_last_drop;
    logic next_res_valid, next_res_hit, next_res_permit, next_res_drop;
    logic entry_en, deny, code_user;
    logic [1:0] src_mode, dst_mode, tos_mode, icmp_mode;
    logic [PORT_W-1:0] src_lo, src_hi, dst_lo, dst_hi;
    logic [8:0] list_entry;
    logic has_l4, src_ok, dst_ok;
    logic [5:0] flag_ok;
    logic tos_ok, icmp_ok, code_ok, all_ok, frame_hit;

    assign entry_en = ctrl[l4ae_pkg::CTRL_EN_BIT];
    assign deny = ctrl[l4ae_pkg::CTRL_DENY_BIT];
    assign src_mode = ctrl[l4ae_pkg::CTRL_SRC_POS +: 2];
    assign dst_mode = ctrl[l4ae_pkg::CTRL_DST_POS +: 2];
    assign tos_mode = ctrl[l4ae_pkg::CTRL_TOS_POS +: 2];
    assign icmp_mode = ctrl[l4ae_pkg::CTRL_ICMP_POS +: 2];
    assign code_user = ctrl[l4ae_pkg::CTRL_CODE_BIT];
    assign src_lo = src_cfg[l4ae_pkg::PORT_LO_POS +: PORT_W];
    assign src_hi = src_cfg[l4ae_pkg::PORT_HI_POS +: PORT_W];
    assign dst_lo = dst_cfg[l4ae_pkg::PORT_LO_POS +: PORT_W];
    assign dst_hi = dst_cfg[l4ae_pkg::PORT_HI_POS +: PORT_W];
    assign list_entry = l4ae_pkg::icmp_list_type(
        icmp_cfg[l4ae_pkg::ICMP_LIST_POS +: 4]);
    assign has_l4 = frm_is_tcp || frm_is_udp;

    // tri-state test of one tcp flag
    function automatic logic flag_match(input logic [1:0] m,
                                        input logic tcp,
                                        input logic b);
        case (m)
            l4ae_pkg::FLAG_SET: return tcp && b; // see R5
            l4ae_pkg::FLAG_UNSET: return !(tcp && b); // see R6
            l4ae_pkg::FLAG_DONT_CARE: return 1'b1; // see R7
            default: return 1'b0;
        endcase
    endfunction

    l4ae_port_match #(
        .PORT_W(PORT_W)
    ) u_src_match (
        .mode(src_mode),
        .lo(src_lo),
        .hi(src_hi),
        .port(frm_src_port),
        .has_port(has_l4),
        .match(src_ok)
    );

    l4ae_port_match #(
        .PORT_W(PORT_W)
    ) u_dst_match (
        .mode(dst_mode),
        .lo(dst_lo),
        .hi(dst_hi),
        .port(frm_dst_port),
        .has_port(has_l4),
        .match(dst_ok)
    );

    // criteria evaluation
    always_comb begin
        for (int i = 0; i < l4ae_pkg::NUM_FLAGS; i++) begin
            flag_ok[i] = flag_match(flag_cfg[2*i +: 2], frm_is_tcp,
                                    frm_tcp_flags[i]);
        end
        case (tos_mode)
            l4ae_pkg::TOS_ANY: tos_ok = 1'b1; // see R8
            l4ae_pkg::TOS_DSCP: tos_ok = frm_is_ip &&
                (frm_tos[7:2] == tos_cfg[l4ae_pkg::TOS_DSCP_POS +: 6]); // see R9
            l4ae_pkg::TOS_PREC: tos_ok = frm_is_ip &&
                (frm_tos[7:5] == tos_cfg[l4ae_pkg::TOS_PREC_POS +: 3]); // see R10
            default: tos_ok = 1'b0;
        endcase
        case (icmp_mode)
            l4ae_pkg::ICMP_ANY: icmp_ok = 1'b1; // see R11
            l4ae_pkg::ICMP_LIST: icmp_ok = frm_is_icmp && list_entry[8] &&
                (frm_icmp_type == list_entry[7:0]); // see R12
            l4ae_pkg::ICMP_PROTO: icmp_ok = frm_is_ip &&
                (frm_ip_proto == icmp_cfg[l4ae_pkg::ICMP_PROTO_POS +: 8]); // see R13
            default: icmp_ok = 1'b0;
        endcase
        if (code_user) begin
            code_ok = frm_is_icmp &&
                (frm_icmp_code == icmp_cfg[l4ae_pkg::ICMP_CODE_POS +: 8]); // see R15
        end else begin
            code_ok = 1'b1; // see R14
        end
        all_ok = entry_en && src_ok && dst_ok && (&flag_ok) &&
                 tos_ok && icmp_ok && code_ok; // see R18
        frame_hit = frm_valid && all_ok;
    end

    // configuration registers
    always_comb begin
        next_ctrl = ctrl;
        next_src_cfg = src_cfg;
        next_dst_cfg = dst_cfg;
        next_flag_cfg = flag_cfg;
        next_tos_cfg = tos_cfg;
        next_icmp_cfg = icmp_cfg;
        if (reg_wr) begin
            case (reg_addr)
                l4ae_pkg::ADDR_CTRL: next_ctrl = reg_wdata & l4ae_pkg::CTRL_MASK;
                l4ae_pkg::ADDR_SRC_PORT: next_src_cfg = reg_wdata;
                l4ae_pkg::ADDR_DST_PORT: next_dst_cfg = reg_wdata;
                l4ae_pkg::ADDR_TCP_FLAGS: begin
                    next_flag_cfg = reg_wdata & l4ae_pkg::FLAGS_MASK;
                end
                l4ae_pkg::ADDR_TOS: next_tos_cfg = reg_wdata & l4ae_pkg::TOS_MASK;
                l4ae_pkg::ADDR_ICMP: begin
                    next_icmp_cfg = reg_wdata & l4ae_pkg::ICMP_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl <= l4ae_pkg::CTRL_RESET;
            src_cfg <= l4ae_pkg::PORT_RESET;
            dst_cfg <= l4ae_pkg::PORT_RESET;
            flag_cfg <= l4ae_pkg::FLAGS_RESET;
            tos_cfg <= l4ae_pkg::TOS_RESET;
            icmp_cfg <= l4ae_pkg::ICMP_RESET;
        end else begin
            ctrl <= next_ctrl;
            src_cfg <= next_src_cfg;
            dst_cfg <= next_dst_cfg;
            flag_cfg <= next_flag_cfg;
            tos_cfg <= next_tos_cfg;
            icmp_cfg <= next_icmp_cfg;
        end
    end

    // decision, action and hit statistics
    always_comb begin
        next_res_valid = frm_valid;
        next_res_hit = frame_hit;
        next_res_permit = frame_hit && !deny; // see R16
        next_res_drop = frame_hit && deny; // see R17
        next_hit_count = hit_count;
        next_last_hit = last_hit;
        next_last_drop = last_drop;
        if (reg_wr && reg_addr == l4ae_pkg::ADDR_STATUS) begin
            next_hit_count = l4ae_pkg::COUNT_RESET;
        end
        // a hit in the clearing cycle still counts
        if (frame_hit) begin
            next_hit_count = 16'(next_hit_count + 16'h0001);
        end
        if (frm_valid) begin
            next_last_hit = all_ok;
            next_last_drop = all_ok && deny;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            res_valid <= 1'b0;
            res_hit <= 1'b0;
            res_permit <= 1'b0;
            res_drop <= 1'b0;
            hit_count <= l4ae_pkg::COUNT_RESET;
            last_hit <= 1'b0;
            last_drop <= 1'b0;
        end else begin
            res_valid <= next_res_valid;
            res_hit <= next_res_hit;
            res_permit <= next_res_permit;
            res_drop <= next_res_drop;
            hit_count <= next_hit_count;
            last_hit <= next_last_hit;
            last_drop <= next_last_drop;
        end
    end

    // read data stands only in the cycle after the read strobe
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                l4ae_pkg::ADDR_CTRL: next_rdata = ctrl;
                l4ae_pkg::ADDR_SRC_PORT: next_rdata = src_cfg;
                l4ae_pkg::ADDR_DST_PORT: next_rdata = dst_cfg;
                l4ae_pkg::ADDR_TCP_FLAGS: next_rdata = flag_cfg;
                l4ae_pkg::ADDR_TOS: next_rdata = tos_cfg;
                l4ae_pkg::ADDR_ICMP: next_rdata = icmp_cfg;
                l4ae_pkg::ADDR_STATUS: begin
                    next_rdata = {14'h0000, last_drop, last_hit, hit_count};
                end
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence frame_hit_s;
        frm_valid && all_ok;
    endsequence

    sequence answer_hit_s;
        res_valid && res_hit;
    endsequence

    sequence answer_miss_s;
        res_valid && !res_hit && !res_permit && !res_drop;
    endsequence

    hit_answer_a: assert property (frame_hit_s |=> answer_hit_s) // see R18
        else $error("hit not reported one cycle after matching frame");
    miss_answer_a: assert property (frm_valid && !all_ok |=> answer_miss_s) // see R18
        else $error("miss reported as hit");
    disabled_miss_a: assert property (!entry_en && frm_valid |=> // see R18
        res_valid && !res_hit)
        else $error("disabled entry matched");
    deny_drop_a: assert property (frame_hit_s ##0 deny |=> // see R17
        answer_hit_s ##0 (res_drop && !res_permit))
        else $error("deny hit not dropped");
    permit_fwd_a: assert property (frame_hit_s ##0 !deny |=> // see R16
        answer_hit_s ##0 (res_permit && !res_drop))
        else $error("permit hit not forwarded");
    src_range_a: assert property ( // see R1
        src_mode == l4ae_pkg::PMODE_RANGE |-> src_ok ==
        (has_l4 && frm_src_port >= src_lo && frm_src_port <= src_hi))
        else $error("source range compare wrong");
    dst_any_a: assert property (dst_mode == l4ae_pkg::PMODE_ANY |-> dst_ok) // see R2
        else $error("destination any did not match");
    dst_single_a: assert property ( // see R3
        dst_mode == l4ae_pkg::PMODE_SINGLE |->
        dst_ok == (has_l4 && frm_dst_port == dst_lo))
        else $error("destination single compare wrong");
    dst_range_a: assert property ( // see R4
        dst_mode == l4ae_pkg::PMODE_RANGE |-> dst_ok ==
        (has_l4 && frm_dst_port >= dst_lo && frm_dst_port <= dst_hi))
        else $error("destination range compare wrong");
    range_inverted_a: assert property ( // see R19
        src_mode == l4ae_pkg::PMODE_RANGE && src_lo > src_hi |-> !src_ok)
        else $error("inverted range matched");

    for (genvar g = 0; g < 6; g++) begin : g_flag_chk
        flag_set_a: assert property ( // see R5
            flag_cfg[2*g +: 2] == l4ae_pkg::FLAG_SET |->
            flag_ok[g] == (frm_is_tcp && frm_tcp_flags[g]))
            else $error("flag set option wrong");
        flag_unset_a: assert property ( // see R6
            flag_cfg[2*g +: 2] == l4ae_pkg::FLAG_UNSET && frm_is_tcp &&
            frm_tcp_flags[g] |-> !flag_ok[g])
            else $error("flag unset option accepted set flag");
        flag_any_a: assert property (flag_cfg[2*g +: 2] == // see R7
            l4ae_pkg::FLAG_DONT_CARE |-> flag_ok[g])
            else $error("flag don't care refused frame");
    end

    tos_any_a: assert property (tos_mode == l4ae_pkg::TOS_ANY |-> tos_ok) // see R8
        else $error("tos any refused frame");
    tos_dscp_a: assert property (tos_mode == l4ae_pkg::TOS_DSCP && // see R9
        tos_ok |-> frm_is_ip && frm_tos[7:2] == tos_cfg[5:0])
        else $error("dscp compare wrong");
    tos_prec_a: assert property (tos_mode == l4ae_pkg::TOS_PREC && // see R10
        tos_ok |-> frm_is_ip && frm_tos[7:5] == tos_cfg[10:8])
        else $error("precedence compare wrong");
    icmp_any_a: assert property (icmp_mode == l4ae_pkg::ICMP_ANY |-> icmp_ok) // see R11
        else $error("icmp any refused frame");
    icmp_list_a: assert property (icmp_mode == l4ae_pkg::ICMP_LIST && // see R12
        icmp_ok |-> frm_is_icmp && frm_icmp_type == list_entry[7:0])
        else $error("icmp list compare wrong");
    icmp_proto_a: assert property (icmp_mode == l4ae_pkg::ICMP_PROTO && // see R13
        icmp_ok |-> frm_ip_proto == icmp_cfg[15:8])
        else $error("protocol id compare wrong");
    code_any_a: assert property (!code_user |-> code_ok) // see R14
        else $error("icmp code any refused frame");
    code_user_a: assert property (code_user |-> code_ok == // see R15
        (frm_is_icmp && frm_icmp_code == icmp_cfg[23:16]))
        else $error("icmp code compare wrong");

    count_clear_a: assert property (reg_wr &&
        reg_addr == l4ae_pkg::ADDR_STATUS |=>
        hit_count == ($past(frame_hit) ? 16'h0001 : 16'h0000))
        else $error("hit counter clear wrong");
    read_ctrl_a: assert property (reg_rd && reg_addr == l4ae_pkg::ADDR_CTRL
        |=> reg_rdata == $past(ctrl) ##1 (reg_rdata == 32'h0 || $past(reg_rd)))
        else $error("control readback wrong");

endmodule

// >>> l4ae_frame_src.sv
// header source standing in for the forwarding pipeline
// assumes the bench hands it one packed header and a send strobe
`timescale 1ns/1ns
module l4ae_frame_src (
    input wire logic clk,
    input wire logic send,
    input wire logic [73:0] hdr,
    output logic frm_valid,
    output logic [73:0] frm_bus
);
    logic [73:0] next_bus;
    always_comb begin
        // between frames the lines carry the inverse, never stale data
        next_bus = send ? hdr : ~hdr;
    end
    always_ff @(posedge clk) begin
        frm_valid <= send;
        frm_bus <= next_bus;
    end
endmodule

// >>> l4_access_entry_matcher_tb_top.sv
// bench: random entry settings and frames checked against a model
// assumes the matcher answers one cycle after each frame
`timescale 1ns/1ns
module l4_access_entry_matcher_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic send = 1'b0;
    logic [73:0] hdr = 74'h0;
    logic [73:0] frm_bus;
    logic frm_valid, frm_is_ip, frm_is_tcp, frm_is_udp, frm_is_icmp;
    logic [7:0] frm_ip_proto, frm_tos, frm_icmp_type, frm_icmp_code;
    logic [15:0] frm_src_port, frm_dst_port;
    logic [5:0] frm_tcp_flags;
    logic res_valid, res_hit, res_permit, res_drop;
    logic [31:0] lfsr = 32'd84122;
    logic [31:0] cfg [6];
    logic last_hit = 1'b0;
    logic last_drop = 1'b0;
    int n_mismatch = 0;
    int comparisons = 0;
    int hits = 0;
    int list_type [11] = '{0, 3, 4, 5, 8, 11, 12, 13, 14, 15, 16};
    logic [31:0] masks [6] = '{l4ae_pkg::CTRL_MASK, 32'hffff_ffff,
        32'hffff_ffff, l4ae_pkg::FLAGS_MASK, l4ae_pkg::TOS_MASK,
        l4ae_pkg::ICMP_MASK};
    logic [31:0] resets [8] = '{l4ae_pkg::CTRL_RESET, l4ae_pkg::PORT_RESET,
        l4ae_pkg::PORT_RESET, l4ae_pkg::FLAGS_RESET, l4ae_pkg::TOS_RESET,
        l4ae_pkg::ICMP_RESET, 32'h0, 32'h0};

    always #5 clk = ~clk;

    assign {frm_is_ip, frm_is_tcp, frm_is_udp, frm_is_icmp, frm_ip_proto,
        frm_src_port, frm_dst_port, frm_tcp_flags, frm_tos, frm_icmp_type,
        frm_icmp_code} = frm_bus;

    l4ae_frame_src SRC (.clk, .send, .hdr, .frm_valid, .frm_bus);
    l4ae_entry_matcher DUT (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .frm_valid, .frm_is_ip, .frm_is_tcp,
        .frm_is_udp, .frm_is_icmp, .frm_ip_proto, .frm_src_port,
        .frm_dst_port, .frm_tcp_flags, .frm_tos, .frm_icmp_type,
        .frm_icmp_code, .res_valid, .res_hit, .res_permit, .res_drop);

    function automatic logic [31:0] rnd();
        for (int i = 0; i < 32; i++)
            lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    function automatic logic pm(logic [1:0] m, logic [31:0] r,
                                logic [15:0] p, logic l4);
        case (m)
            2'h0: return 1'b1;
            2'h1: return l4 && p == r[15:0];
            2'h2: return l4 && p >= r[15:0] && p <= r[31:16];
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic model();
        logic ok;
        logic [1:0] f;
        logic l4;
        l4 = frm_is_tcp | frm_is_udp;
        ok = cfg[0][0];
        ok &= pm(cfg[0][3:2], cfg[1], frm_src_port, l4);
        ok &= pm(cfg[0][5:4], cfg[2], frm_dst_port, l4);
        for (int i = 0; i < 6; i++) begin
            f = cfg[3][2*i +: 2];
            if (f == 2'h3 || (f == 2'h1 && !(frm_is_tcp && frm_tcp_flags[i]))
                || (f == 2'h2 && frm_is_tcp && frm_tcp_flags[i]))
                ok = 1'b0;
        end
        case (cfg[0][7:6])
            2'h1: ok &= frm_is_ip && frm_tos[7:2] == cfg[4][5:0];
            2'h2: ok &= frm_is_ip && frm_tos[7:5] == cfg[4][10:8];
            2'h3: ok = 1'b0;
            default: ;
        endcase
        case (cfg[0][9:8])
            2'h1: ok &= frm_is_icmp && cfg[5][3:0] < 4'hb
                && frm_icmp_type == 8'(list_type[cfg[5][3:0]]);
            2'h2: ok &= frm_is_ip && frm_ip_proto == cfg[5][15:8];
            2'h3: ok = 1'b0;
            default: ;
        endcase
        if (cfg[0][10])
            ok &= frm_is_icmp && frm_icmp_code == cfg[5][23:16];
        return ok;
    endfunction

    function automatic logic [15:0] pick(logic [2:0] s, logic [31:0] r,
                                         logic [15:0] x);
        case (s)
            3'h0: return r[15:0];
            3'h1: return r[31:16];
            3'h2: return r[15:0] - 16'h1;
            3'h3: return r[31:16] + 16'h1;
            default: return x;
        endcase
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, e);
    endtask

    task automatic frame();
        logic [31:0] a, b, c;
        logic e;
        a = rnd();
        b = rnd();
        c = rnd();
        @(posedge clk);
        send <= 1'b1;
        hdr <= {a[16:13] | {a[17], 3'h0},
            a[10] ? cfg[5][15:8] : c[7:0],
            pick(a[2:0], cfg[1], b[15:0]), pick(b[18:16], cfg[2], b[31:16]),
            c[29:24],
            a[3] ? {cfg[4][5:0], a[5:4]} : a[4] ? {cfg[4][10:8], a[9:5]}
                : c[31:24],
            a[11] ? 8'(list_type[cfg[5][3:0]]) : c[15:8],
            a[12] ? cfg[5][23:16] : c[23:16]};
        @(posedge clk);
        send <= 1'b0;
        #1 e = model();
        @(posedge clk);
        #1 check(res_valid, 1);
        check(res_hit, e);
        check(res_hit, e);
        check(res_permit, e & ~cfg[0][1]);
        check(res_drop, e & cfg[0][1]);
        hits += e;
        last_hit = e;
        last_drop = e & cfg[0][1];
    endtask

    task automatic summarize();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #300000;
        n_mismatch++;
        summarize();
    end

    initial begin
        logic [31:0] r;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++)
            rd(8'(i * 4), resets[i]);
        for (int n = 0; n < 400; n++) begin
            for (int i = 0; i < 6; i++) begin
                r = rnd();
                r = (i == 0) ? ((rnd() & rnd() & 32'h7fe) | 32'(r[0] | r[1]))
                    : (i == 3) ? rnd() & rnd() : rnd();
                cfg[i] = r & masks[i];
                wr(8'(i * 4), r);
            end
            for (int i = 0; i < 6; i++)
                rd(8'(i * 4), cfg[i]);
            frame();
            frame();
            rd(l4ae_pkg::ADDR_STATUS, {14'h0, last_drop, last_hit,
                hits[15:0]});
            wr(l4ae_pkg::ADDR_STATUS, 32'h0);
            hits = 0;
        end
        summarize();
    end
endmodule
